//--- burst_order_and_dll_off_switch.v
// Burst ordering, write timing and DLL-off control with an AXI4-Lite slave.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "burst_dll_defines.vh"
module burst_order_and_dll_off_switch #(
  parameter SR_EXIT_FULL_CYCLES  = 16'd20,
  parameter SR_EXIT_ABORT_CYCLES = 16'd10
) (
  input  wire        i_clock,
  input  wire        i_nrst,
  input  wire [4:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [4:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg  [2:0]  o_beat_col,
  output reg         o_beat_valid,
  output reg         o_dq_oe,
  output reg         o_write_start,
  output reg         o_dll_enable,
  output reg         o_refresh_abort,
  output reg         o_cmd_ready
);
  localparam S_IDLE  = 4'b0001;
  localparam S_BURST = 4'b0010;
  localparam S_WAIT  = 4'b0100;
  localparam S_EXIT  = 4'b1000;

  function is_mapped;
    input [4:0] a;
    begin
      is_mapped = (a == `REG_BURST_LATENCY) || (a == `REG_DLL_ENABLE) ||
                  (a == `REG_REFRESH_ABORT) || (a == `REG_CMD) || (a == `REG_STATUS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  reg [31:0] burst_q;
  reg [31:0] dll_q;
  reg [31:0] abort_q;
  reg [4:0]  awaddr_q;
  reg        aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        w_have_q;
  reg [3:0]  state_q;
  reg [3:0]  beat_q;
  reg [2:0]  start_q;
  reg        chop_q;
  reg        write_q;
  reg        inter_q;
  reg [3:0]  wdelay_q;
  reg [15:0] exit_q;
  reg        refresh_aborted_q;
  reg        valid_q;
  wire [2:0] col_w;
  wire       do_write = aw_have_q && w_have_q && !o_bvalid;
  wire [1:0] bl_mode  = burst_q[`BL_HI:`BL_LO];
  wire       cmd_go   = do_write && (awaddr_q == `REG_CMD) && (state_q == S_IDLE);
  wire [1:0] cmd_op   = wdata_q[1:0];
  wire       cmd_chop = (bl_mode == `BL_FIXED4) ||
                        ((bl_mode == `BL_OTF) && wdata_q[`CMD_CHOP_BIT]);
  wire       crc8     = burst_q[`CRC_BIT] && (bl_mode == `BL_FIXED8);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Write channels are taken independently and answered once both are held.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 5'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `AXI_OKAY;
      burst_q   <= `RST_BURST;
      dll_q     <= `RST_DLL;
      abort_q   <= `RST_ABORT;
    end else begin
      o_awready <= !aw_have_q && !o_awready && i_awvalid;
      o_wready  <= !w_have_q && !o_wready && i_wvalid;
      if (o_awready && i_awvalid) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= is_mapped(awaddr_q) ? `AXI_OKAY : `AXI_SLVERR;
        case (awaddr_q)
          `REG_BURST_LATENCY: burst_q <= merge(burst_q, wdata_q, wstrb_q);
          `REG_DLL_ENABLE:    dll_q   <= merge(dll_q, wdata_q, wstrb_q);
          `REG_REFRESH_ABORT: abort_q <= merge(abort_q, wdata_q, wstrb_q);
          default:            burst_q <= burst_q;
        endcase
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle to accept, next cycle data.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= `AXI_OKAY;
    end else begin
      o_arready <= !o_rvalid && !o_arready && i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp  <= is_mapped(i_araddr) ? `AXI_OKAY : `AXI_SLVERR;
        case (i_araddr)
          `REG_BURST_LATENCY: o_rdata <= burst_q;
          `REG_DLL_ENABLE:    o_rdata <= dll_q;
          `REG_REFRESH_ABORT: o_rdata <= abort_q;
          `REG_STATUS:        o_rdata <= {26'h0, refresh_aborted_q, state_q, o_dll_enable};
          default:            o_rdata <= 32'h0;
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst sequencer and self refresh exit timer.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q           <= S_IDLE;
      beat_q            <= 4'h0;
      start_q           <= 3'h0;
      chop_q            <= 1'b0;
      write_q           <= 1'b0;
      inter_q           <= 1'b0;
      wdelay_q          <= 4'h0;
      exit_q            <= 16'h0;
      refresh_aborted_q <= 1'b0;
      valid_q           <= 1'b0;
      o_write_start     <= 1'b0;
    end else begin
      o_write_start <= 1'b0;
      valid_q       <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cmd_go && (cmd_op == `CMD_READ || cmd_op == `CMD_WRITE)) begin
            state_q <= S_BURST;
            beat_q  <= 4'h0;
            chop_q  <= cmd_chop;
            write_q <= (cmd_op == `CMD_WRITE);
            inter_q <= burst_q[`BT_BIT];
            // Write CRC with fixed eight-beat bursts pins only writes to the zero start.
            start_q <= (crc8 && cmd_op == `CMD_WRITE) ? 3'h0 :
                       wdata_q[`CMD_COL_HI:`CMD_COL_LO];
            if (cmd_op == `CMD_WRITE) begin
              wdelay_q <= (bl_mode == `BL_FIXED4) ?
                          `WRITE_START_BASE - `CHOP_PULL_IN : `WRITE_START_BASE;
            end else begin
              wdelay_q <= 4'h0;
            end
          end else if (cmd_go && cmd_op == `CMD_SRX) begin
            state_q           <= S_EXIT;
            refresh_aborted_q <= abort_q[`ABORT_BIT];
            exit_q <= abort_q[`ABORT_BIT] ? SR_EXIT_ABORT_CYCLES : SR_EXIT_FULL_CYCLES;
          end
        end
        S_BURST: begin
          valid_q <= 1'b1;
          beat_q  <= beat_q + 4'h1;
          if (beat_q == `BEATS - 4'h1) begin
            state_q <= write_q ? S_WAIT : S_IDLE;
          end
        end
        S_WAIT: begin
          if (wdelay_q == 4'h0) begin
            o_write_start <= 1'b1;
            state_q       <= S_IDLE;
          end else begin
            wdelay_q <= wdelay_q - 4'h1;
          end
        end
        S_EXIT: begin
          // The exit state lasts one cycle beyond the loaded count.
          if (exit_q == 16'h0) begin
            state_q <= S_IDLE;
          end else begin
            exit_q <= exit_q - 16'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  beat_order_rom u_rom (
    .i_clock      (i_clock),
    .i_nrst       (i_nrst),
    .i_start      (start_q),
    .i_beat       (beat_q[2:0]),
    .i_interleave (inter_q),
    .i_write      (write_q),
    .i_chop       (chop_q),
    .o_col        (col_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers aligned with the lookup.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_beat_col      <= 3'h0;
      o_beat_valid    <= 1'b0;
      o_dq_oe         <= 1'b0;
      o_dll_enable    <= 1'b1;
      o_refresh_abort <= 1'b0;
      o_cmd_ready     <= 1'b0;
    end else begin
      o_beat_col      <= col_w;
      o_beat_valid    <= valid_q;
      // The beat counter runs one slot ahead of the column on the outputs.
      o_dq_oe         <= valid_q && !write_q &&
                         !(chop_q && beat_q > `HALF_BEATS);
      o_dll_enable    <= dll_q[`DLL_BIT];
      o_refresh_abort <= refresh_aborted_q;
      o_cmd_ready     <= (state_q == S_IDLE);
    end
  end
endmodule

//--- burst_dll_defines.vh
// Constants for the burst ordering and DLL-off switch block.
`ifndef BURST_DLL_DEFINES_VH
`define BURST_DLL_DEFINES_VH
// AXI4-Lite register byte offsets.
`define REG_BURST_LATENCY  5'h00
`define REG_DLL_ENABLE     5'h04
`define REG_REFRESH_ABORT  5'h08
`define REG_CMD            5'h0c
`define REG_STATUS         5'h10
// Field positions.
`define BL_LO              0
`define BL_HI              1
`define BT_BIT             3
`define CRC_BIT            12
`define DLL_BIT            0
`define ABORT_BIT          9
// Burst length codes.
`define BL_FIXED8          2'h0
`define BL_OTF             2'h1
`define BL_FIXED4          2'h2
// Command register layout.
`define CMD_READ           2'h1
`define CMD_WRITE          2'h2
`define CMD_SRX            2'h3
`define CMD_CHOP_BIT       2
`define CMD_COL_LO         4
`define CMD_COL_HI         6
// Timing.
`define CHOP_PULL_IN       4'h2
`define WRITE_START_BASE   4'h4
`define BEATS              4'h8
`define HALF_BEATS         4'h4
// Reset values and AXI response codes.
`define RST_BURST          32'h0000_0000
`define RST_DLL            32'h0000_0001
`define RST_ABORT          32'h0000_0000
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2
`endif

//--- beat_order_rom.v
// Registered beat order lookup for one burst beat.
`timescale 1ns/100ps
`include "burst_dll_defines.vh"
module beat_order_rom (
  input  wire       i_clock,
  input  wire       i_nrst,
  input  wire [2:0] i_start,
  input  wire [2:0] i_beat,
  input  wire       i_interleave,
  input  wire       i_write,
  input  wire       i_chop,
  output reg  [2:0] o_col
);
  reg [2:0] col_d;
  always @* begin
    if (i_write) begin
      col_d = i_chop ? {i_start[2], i_beat[1:0]} : i_beat;
    end else if (i_interleave) begin
      col_d = i_start ^ i_beat;
    end else begin
      col_d = {i_start[2] ^ i_beat[2], i_start[1:0] + i_beat[1:0]};
    end
  end
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col <= 3'h0;
    end else begin
      o_col <= col_d;
    end
  end
endmodule

//--- bdo_props.sv
// Checker for the beat stream and register bus timing.
`timescale 1ns/100ps
module bdo_props (
  input wire       i_clock,
  input wire       i_nrst,
  input wire       i_bready,
  input wire       o_awready,
  input wire       o_bvalid,
  input wire       o_arready,
  input wire       o_rvalid,
  input wire [2:0] o_beat_col,
  input wire       o_beat_valid,
  input wire       o_dq_oe,
  input wire       o_write_start,
  input wire       o_dll_enable
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  property p_len; $rose(o_beat_valid) |-> o_beat_valid [*8] ##1 !o_beat_valid; endproperty
  a_len: assert property (p_len) else $error("burst not eight slots");
  property p_oe; o_dq_oe |-> o_beat_valid; endproperty
  a_oe: assert property (p_oe) else $error("driver on outside burst");
  property p_dist; o_dq_oe && $past(o_dq_oe) |-> o_beat_col != $past(o_beat_col); endproperty
  a_dist: assert property (p_dist) else $error("read beat repeated");
  property p_ws; o_write_start |-> !o_dq_oe ##1 !o_write_start; endproperty
  a_ws: assert property (p_ws) else $error("write start not a pulse");
  property p_dll; $changed(o_dll_enable) |-> $past(o_bvalid); endproperty
  a_dll: assert property (p_dll) else $error("dll enable moved without a write");
  property p_b; o_bvalid && i_bready |=> !o_bvalid; endproperty
  a_b: assert property (p_b) else $error("write response repeated");
  property p_r; $rose(o_rvalid) |-> $past(o_arready); endproperty
  a_r: assert property (p_r) else $error("read data without address accept");
  property p_aw; o_awready |=> !o_awready; endproperty
  a_aw: assert property (p_aw) else $error("awready longer than a pulse");
endmodule
bind burst_order_and_dll_off_switch bdo_props u_props (.*);

//--- ctl_model.sv
// Memory controller model: AXI4-Lite master reaching the mode and command registers.
`timescale 1ns/100ps
module ctl_model (
  input  wire        i_clock,
  output reg  [4:0]  o_awaddr = 5'h0,
  output reg         o_awvalid = 1'b0,
  output reg  [31:0] o_wdata = 32'h0,
  output reg  [3:0]  o_wstrb = 4'h0,
  output reg         o_wvalid = 1'b0,
  output reg         o_bready = 1'b0,
  output reg  [4:0]  o_araddr = 5'h0,
  output reg         o_arvalid = 1'b0,
  output reg         o_rready = 1'b0,
  input  wire        i_awready,
  input  wire        i_wready,
  input  wire [1:0]  i_bresp,
  input  wire        i_bvalid,
  input  wire        i_arready,
  input  wire [31:0] i_rdata,
  input  wire        i_rvalid
);
  task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clock);
    o_awaddr <= a;
    o_wdata <= d;
    o_wstrb <= 4'hf;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_awready) o_awvalid <= 1'b0;
      if (i_wready) o_wvalid <= 1'b0;
    end while (i_bvalid !== 1'b1);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  task rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clock);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_arready) o_arvalid <= 1'b0;
    end while (i_rvalid !== 1'b1);
    d = i_rdata;
    o_rready <= 1'b0;
  endtask
endmodule

//--- test_burst_order_and_dll_off_switch.sv
// Self-checking bench for burst ordering and DLL-off control.
`timescale 1ns/100ps
`include "burst_dll_defines.vh"
module test_burst_order_and_dll_off_switch;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  wire [4:0] i_awaddr, i_araddr;
  wire [31:0] i_wdata, o_rdata;
  wire [3:0] i_wstrb;
  wire [1:0] o_bresp, o_rresp;
  wire i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  wire i_arvalid, o_arready, o_rvalid, i_rready;
  wire [2:0] o_beat_col;
  wire o_beat_valid, o_dq_oe, o_write_start, o_dll_enable, o_refresh_abort, o_cmd_ready;
  int n_fail = 0;
  int n_compared = 0;
  int k, j, n, t8;
  logic [31:0] d;
  logic [1:0] r, sz;
  logic bt, crc;
  burst_order_and_dll_off_switch dut (.*);
  ctl_model m (.i_clock, .o_awaddr(i_awaddr), .o_awvalid(i_awvalid), .o_wdata(i_wdata),
    .o_wstrb(i_wstrb), .o_wvalid(i_wvalid), .o_bready(i_bready), .o_araddr(i_araddr),
    .o_arvalid(i_arvalid), .o_rready(i_rready), .i_awready(o_awready), .i_wready(o_wready),
    .i_bresp(o_bresp), .i_bvalid(o_bvalid), .i_arready(o_arready), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [2:0] ecol(bit wr, bit ch, logic [2:0] s, logic [2:0] b);
    if (wr) return ch ? {s[2], b[1:0]} : b;
    if (bt) return s ^ b;
    return {s[2] ^ b[2], s[1:0] + b[1:0]};
  endfunction
  // Issues one column command and checks its eight beat slots against the model.
  task op(input bit wr, input bit cs, input logic [2:0] s);
    bit ch;
    ch = (sz == `BL_FIXED4) || (sz == `BL_OTF && cs);
    if (crc && sz == `BL_FIXED8 && wr) s = 3'h0;
    m.wr(`REG_CMD, {25'h0, s, 1'b0, cs, wr ? `CMD_WRITE : `CMD_READ}, r);
    n = 0;
    while (o_beat_valid !== 1'b1 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    for (j = 0; j < 8; j++) begin
      chk(o_dq_oe, !wr && !(ch && j > 3), "driver enable");
      if (!(ch && j > 3)) chk(o_beat_col, ecol(wr, ch, s, j), "beat column");
      @(negedge i_clock);
    end
    n = 0;
    while (wr && o_write_start !== 1'b1 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  initial begin
    #500us;
    n_fail++;
    conclude;
  end
  initial begin
    k = $urandom(77484);
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (k = 0; k < 3; k++) begin
      m.rd(k * 4, d);
      chk(d, k == 1 ? `RST_DLL : `RST_BURST, "reset value");
    end
    m.rd(5'h14, d);
    chk(d, 32'h0, "unmapped read");
    chk(o_rresp, `AXI_SLVERR, "unmapped read response");
    m.wr(5'h14, 32'h1, r);
    chk(r, `AXI_SLVERR, "unmapped write");
    $display("register map test done");
    for (k = 0; k < 12; k++) begin
      sz = k % 3;
      bt = (k / 3) % 2;
      crc = k / 6;
      m.wr(`REG_BURST_LATENCY, {19'h0, crc, 8'h0, bt, 1'b0, sz}, r);
      chk(r, `AXI_OKAY, "mode write");
      op(1'b0, $urandom % 2, $urandom % 8);
      op(1'b1, 1'b1, $urandom % 8);
      if (sz == `BL_FIXED8) t8 = n;
      else chk(n, sz == `BL_FIXED4 ? t8 - 2 : t8, "write start delay");
    end
    $display("burst order test done");
    m.wr(`REG_DLL_ENABLE, 32'h0, r);
    @(negedge i_clock);
    chk(o_dll_enable, 1'b0, "dll off");
    m.rd(`REG_STATUS, d);
    chk(d[0], 1'b0, "status dll");
    repeat (4) @(posedge i_clock);
    for (k = 0; k < 2; k++) begin
      m.wr(`REG_REFRESH_ABORT, k << `ABORT_BIT, r);
      m.wr(`REG_CMD, `CMD_SRX, r);
      n = 0;
      @(negedge i_clock);
      while (o_cmd_ready !== 1'b1 && n < 100) begin
        n++;
        @(negedge i_clock);
      end
      // The busy span is the loaded count plus the cycle that returns to idle.
      chk(n, (k ? dut.SR_EXIT_ABORT_CYCLES : dut.SR_EXIT_FULL_CYCLES) + 1, "exit busy");
      chk(o_refresh_abort, k, "abort latch");
    end
    m.wr(`REG_DLL_ENABLE, 32'h1, r);
    @(negedge i_clock);
    chk(o_dll_enable, 1'b1, "dll on");
    $display("dll switch test done");
    conclude;
  end
endmodule
